// ==== include/eeprom_seq_pkg.sv ====
package eeprom_seq_pkg;

    // Sequence geometry: three entries of instruction byte plus address pair
    localparam int ENTRIES         = 3;
    localparam int BYTES_PER_ENTRY = 3;
    localparam int SEQ_BYTES       = ENTRIES * BYTES_PER_ENTRY;

    // Register indices; byte address on the bus is four times the index
    localparam logic [13:0] IDX_OUT_ANALOG_ZERO_INSTR     = 14'h0e2b;
    localparam logic [13:0] IDX_OUT_ANALOG_ZERO_ADDR      = 14'h0e2c;
    localparam logic [13:0] IDX_LOOP_ZERO_DIVIDER_INSTR   = 14'h0e2e;
    localparam logic [13:0] IDX_LOOP_ZERO_DIVIDER_ADDR    = 14'h0e2f;
    localparam logic [13:0] IDX_LOOP_ONE_GENERAL_INSTR    = 14'h0e31;
    localparam logic [13:0] IDX_LOOP_ONE_GENERAL_ADDR     = 14'h0e32;
    localparam logic [13:0] IDX_SEQ_FIRST                 = IDX_OUT_ANALOG_ZERO_INSTR;
    localparam logic [13:0] IDX_CTRL                      = 14'h0e40;
    localparam logic [13:0] IDX_STATUS                    = 14'h0e41;
    localparam logic [13:0] IDX_POINTER                   = 14'h0e42;

    // Reset values of the sequence entries
    localparam logic [7:0]  RST_OUT_ANALOG_ZERO_INSTR     = 8'h0e;
    localparam logic [15:0] RST_OUT_ANALOG_ZERO_ADDR      = 16'h0430;
    localparam logic [7:0]  RST_LOOP_ZERO_DIVIDER_INSTR   = 8'h33;
    localparam logic [15:0] RST_LOOP_ZERO_DIVIDER_ADDR    = 16'h0440;
    localparam logic [7:0]  RST_LOOP_ONE_GENERAL_INSTR    = 8'h1e;
    localparam logic [15:0] RST_LOOP_ONE_GENERAL_ADDR     = 16'h0500;

    // Byte image, element 0 is the lowest sequence index; the upper address byte sits first
    localparam logic [SEQ_BYTES-1:0][7:0] SEQ_RESET = {
        RST_LOOP_ONE_GENERAL_ADDR[7:0],  RST_LOOP_ONE_GENERAL_ADDR[15:8],  RST_LOOP_ONE_GENERAL_INSTR,
        RST_LOOP_ZERO_DIVIDER_ADDR[7:0], RST_LOOP_ZERO_DIVIDER_ADDR[15:8], RST_LOOP_ZERO_DIVIDER_INSTR,
        RST_OUT_ANALOG_ZERO_ADDR[7:0],   RST_OUT_ANALOG_ZERO_ADDR[15:8],   RST_OUT_ANALOG_ZERO_INSTR};

    // Control and status fields
    localparam int CTRL_START_BIT  = 0;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;

    // Pointer steps for the header of each entry
    localparam logic [15:0] PTR_STEP_INSTR  = 16'h0001;
    localparam logic [15:0] PTR_STEP_HEADER = 16'h0003;

    typedef enum logic [3:0] {
        S_IDLE, S_INSTR, S_AHI, S_ALO, S_MREQ, S_MWAIT, S_MPUT, S_DONE
    } seq_state_e;

    // One byte bound for the external memory
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } ee_wr_s;

endpackage

// ==== rtl/seq_regfile.sv ====
`timescale 1ns/100ps
module seq_regfile
    import eeprom_seq_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wr_en_i,
    input  wire logic [3:0]                wr_idx_i,
    input  wire logic [7:0]                wr_data_i,
    output logic      [SEQ_BYTES-1:0][7:0] seq_o
);

    // One byte register per sequence location, loaded with its default
    for (genvar g = 0; g < SEQ_BYTES; g++) begin : g_byte
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                seq_o[g] <= SEQ_RESET[g];
            end else if (wr_en_i && wr_idx_i == 4'(g)) begin
                seq_o[g] <= wr_data_i;
            end
        end
    end

endmodule

// ==== rtl/ee_byte_port.sv ====
`timescale 1ns/100ps
module ee_byte_port
    import eeprom_seq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        clear_i,
    input  wire logic        put_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        ee_ready_i,
    output ee_wr_s           ee_req_o,
    output logic             ee_valid_o,
    output logic [15:0]      ptr_o
);

    // Pointer advances when a byte is accepted, so it always names the next free cell
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            ptr_o <= 16'h0000;
        end else if (put_i && !ee_valid_o) begin
            ptr_o <= ptr_o + 16'h0001;
        end
    end

    // Single holding stage; the memory side stalls us by holding ready low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ee_valid_o <= 1'b0;
            ee_req_o   <= '0;
        end else if (put_i && !ee_valid_o) begin
            ee_valid_o    <= 1'b1;
            ee_req_o.addr <= ptr_o;
            ee_req_o.data <= byte_i;
        end else if (ee_ready_i) begin
            ee_valid_o <= 1'b0;
        end
    end

endmodule

// ==== rtl/eeprom_store_sequencer.sv ====
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
module eeprom_store_sequencer
    import eeprom_seq_pkg::*;
#(
    parameter int WB_AW = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [WB_AW-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Register map read port
    output logic                  map_rd_o,
    output logic      [15:0]      map_addr_o,
    input  wire logic             map_ack_i,
    input  wire logic [7:0]       map_data_i,
    // External memory byte writes
    output ee_wr_s                ee_req_o,
    output logic                  ee_valid_o,
    input  wire logic             ee_ready_i
);

    // Address must reach the sequence and control indices
    if (WB_AW < 16) begin : g_bad_width
        $error("WB_AW must be at least 16");
    end

    seq_state_e               state;
    logic [SEQ_BYTES-1:0][7:0] seq;
    logic [1:0]               entry;
    logic [7:0]               remain;
    logic [15:0]              cur_addr;
    logic [7:0]               map_byte;
    logic                     done;
    logic [15:0]              ptr;
    logic [15:0]              entry_base;
    logic [8:0]               moved;
    logic [13:0]              idx;
    logic                     bus_req;
    logic                     bus_wr;
    logic                     seq_hit;
    logic [3:0]               seq_idx;
    logic                     start;
    logic                     done_clr;
    logic                     put;
    logic [7:0]               put_byte;
    logic [7:0]               cur_instr;
    logic [7:0]               cur_hi;
    logic [7:0]               cur_lo;
    logic                     busy;

    // Bus decode; a request is served once, in the cycle before ack rises
    assign idx      = wb_adr_i[15:2];
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
    assign seq_hit  = (idx >= IDX_SEQ_FIRST) && (idx < IDX_SEQ_FIRST + 14'(SEQ_BYTES));
    assign seq_idx  = 4'(idx - IDX_SEQ_FIRST);
    assign busy     = (state != S_IDLE);
    assign start    = bus_wr && (idx == IDX_CTRL) && wb_dat_i[CTRL_START_BIT] && !busy;
    assign done_clr = bus_wr && (idx == IDX_STATUS) && wb_dat_i[STAT_DONE_BIT];

    // Sequence bytes cannot change under a running pass
    seq_regfile u_seq (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (bus_wr && seq_hit && !busy),
        .wr_idx_i  (seq_idx),
        .wr_data_i (wb_dat_i[7:0]),
        .seq_o     (seq)
    );

    // Current entry's three header bytes, ascending through the sequence
    always_comb begin
        cur_instr = seq[3 * entry];
        cur_hi    = seq[3 * entry + 1];
        cur_lo    = seq[3 * entry + 2];
    end

    // Byte offered to the memory port in each writing state
    always_comb begin
        put      = 1'b0;
        put_byte = 8'h00;
        case (state)
            S_INSTR: begin
                put      = !ee_valid_o;
                put_byte = cur_instr;
            end
            S_AHI: begin
                put      = !ee_valid_o;
                put_byte = cur_hi;
            end
            S_ALO: begin
                put      = !ee_valid_o;
                put_byte = cur_lo;
            end
            S_MPUT: begin
                put      = !ee_valid_o;
                put_byte = map_byte;
            end
            default: begin
                put      = 1'b0;
                put_byte = 8'h00;
            end
        endcase
    end

    ee_byte_port u_port (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .clear_i    (start),
        .put_i      (put),
        .byte_i     (put_byte),
        .ee_ready_i (ee_ready_i),
        .ee_req_o   (ee_req_o),
        .ee_valid_o (ee_valid_o),
        .ptr_o      (ptr)
    );

    // Sequencer: header bytes first, then the data move, then the next entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state    <= S_IDLE;
            entry    <= 2'd0;
            remain   <= 8'h00;
            cur_addr <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        entry <= 2'd0;
                        state <= S_INSTR;
                    end
                end
                S_INSTR: begin
                    if (put) begin
                        remain <= cur_instr;
                        state  <= S_AHI;
                    end
                end
                S_AHI: begin
                    if (put) begin
                        cur_addr[15:8] <= cur_hi;
                        state          <= S_ALO;
                    end
                end
                S_ALO: begin
                    if (put) begin
                        cur_addr[7:0] <= cur_lo;
                        state         <= S_MREQ;
                    end
                end
                S_MREQ: begin
                    state <= S_MWAIT;
                end
                S_MWAIT: begin
                    if (map_ack_i) begin
                        state <= S_MPUT;
                    end
                end
                S_MPUT: begin
                    if (put) begin
                        cur_addr <= cur_addr + 16'h0001;
                        if (remain != 8'h00) begin
                            remain <= remain - 8'h01;
                            state  <= S_MREQ;
                        end else if (entry == 2'(ENTRIES - 1)) begin
                            state <= S_DONE;
                        end else begin
                            entry <= entry + 2'd1;
                            state <= S_INSTR;
                        end
                    end
                end
                S_DONE: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Register map read handshake; the byte is held until the port takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_rd_o   <= 1'b0;
            map_addr_o <= 16'h0000;
            map_byte   <= 8'h00;
        end else if (state == S_MREQ) begin
            map_rd_o   <= 1'b1;
            map_addr_o <= cur_addr;
        end else if (state == S_MWAIT && map_ack_i) begin
            map_rd_o <= 1'b0;
            map_byte <= map_data_i;
        end
    end

    // Sticky completion flag; a finishing pass beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done <= 1'b0;
        end else if (state == S_DONE) begin
            done <= 1'b1;
        end else if (done_clr) begin
            done <= 1'b0;
        end
    end

    // Helper state for checking: pointer at entry start and bytes moved so far
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            entry_base <= 16'h0000;
            moved      <= 9'd0;
        end else if (state == S_INSTR && put) begin
            entry_base <= ptr;
            moved      <= 9'd0;
        end else if (state == S_MPUT && put) begin
            moved <= moved + 9'd1;
        end
    end

    // Bus slave: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                if (seq_hit) begin
                    wb_dat_o <= {24'h00_0000, seq[seq_idx]};
                end else if (idx == IDX_STATUS) begin
                    wb_dat_o <= {30'h0000_0000, done, busy};
                end else if (idx == IDX_POINTER) begin
                    wb_dat_o <= {16'h0000, ptr};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // Checks
    sequence s_instr_taken;
        state == S_INSTR && put;
    endsequence

    sequence s_last_data_taken;
        state == S_MPUT && put && remain == 8'h00;
    endsequence

    a_instr_byte_stored: assert property (@(posedge clk_i) disable iff (rst_i)
        s_instr_taken |=> ee_valid_o && ee_req_o.data == $past(cur_instr) && ptr == $past(ptr) + PTR_STEP_INSTR)
        else $error("instruction byte not stored or pointer not advanced by one");

    a_count_from_instr: assert property (@(posedge clk_i) disable iff (rst_i)
        s_instr_taken |=> remain == $past(cur_instr))
        else $error("move count not taken from instruction");

    a_header_before_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == S_MREQ && moved == 9'd0) |-> ptr == entry_base + PTR_STEP_HEADER)
        else $error("address bytes not written before data");

    a_addr_hi_lo: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == S_ALO && put) |=> cur_addr == {$past(cur_hi), $past(cur_lo)})
        else $error("start address halves in wrong order");

    a_move_length: assert property (@(posedge clk_i) disable iff (rst_i)
        s_last_data_taken |=> moved == 9'($past(cur_instr)) + 9'd1
            && ptr == entry_base + PTR_STEP_HEADER + 16'(moved))
        else $error("data move length differs from instruction plus one");

    a_map_addr_walk: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == S_MREQ) |=> map_rd_o && map_addr_o == {cur_hi, cur_lo} + 16'(moved))
        else $error("register map address not start plus bytes moved");

    a_next_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_last_data_taken and (entry != 2'(ENTRIES - 1))) |=> state == S_INSTR && entry == $past(entry) + 2'd1)
        else $error("next entry not taken right after data move");

    a_reset_defaults: assert property (@(posedge clk_i)
        rst_i |=> seq[0] == RST_OUT_ANALOG_ZERO_INSTR && {seq[1], seq[2]} == RST_OUT_ANALOG_ZERO_ADDR
            && seq[3] == RST_LOOP_ZERO_DIVIDER_INSTR && {seq[4], seq[5]} == RST_LOOP_ZERO_DIVIDER_ADDR
            && seq[6] == RST_LOOP_ONE_GENERAL_INSTR && {seq[7], seq[8]} == RST_LOOP_ONE_GENERAL_ADDR)
        else $error("sequence bytes not at reset defaults");

    a_done_ends_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_last_data_taken and (entry == 2'(ENTRIES - 1))) |=> state == S_DONE ##1 done && !busy)
        else $error("pass did not finish after last entry");

endmodule

// ==== bench/eeprom_model.sv ====
`timescale 1ns/100ps
module eeprom_model
    import eeprom_seq_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire ee_wr_s req_i,
    input  wire logic   valid_i,
    input  wire logic   slow_i,
    output logic        ready_o,
    output logic [15:0] n_wr_o
);
    logic [7:0] mem [0:255];

    // Slow mode toggles ready so the sequencer must hold each byte across stalls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            n_wr_o  <= 16'h0000;
        end else begin
            ready_o <= slow_i ? ~ready_o : 1'b1;
            if (valid_i && ready_o) begin
                mem[req_i.addr[7:0]] <= req_i.data;
                n_wr_o               <= n_wr_o + 16'h0001;
            end
        end
    end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench
    import eeprom_seq_pkg::*;
;
    `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
        $display("wrong value t=%0t got %h exp %h", $time, got, exp); end end

    logic        clk_i, rst_i, cyc, stb, we, map_ack, slow_mode;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, d;
    logic        ack, map_rd, ee_valid, ee_ready;
    logic [15:0] map_addr, n_wr;
    logic [7:0]  map_data;
    ee_wr_s      ee_req;
    int          err_total, n_tests, cyc_cnt;
    logic [8:0][7:0] dflt, cust;

    eeprom_store_sequencer u_eeprom_store_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .map_rd_o(map_rd), .map_addr_o(map_addr), .map_ack_i(map_ack), .map_data_i(map_data),
        .ee_req_o(ee_req), .ee_valid_o(ee_valid), .ee_ready_i(ee_ready));

    eeprom_model u_eeprom_model (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(ee_req), .valid_i(ee_valid),
        .slow_i(slow_mode), .ready_o(ee_ready), .n_wr_o(n_wr));

    // Register map content is a fixed function of its address
    function automatic logic [7:0] map_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction

    // Register map answers after one or more cycles; data flips when idle
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (map_rd && !map_ack && (!slow_mode || cyc_cnt[0])) begin
            map_ack  <= 1'b1;
            map_data <= map_byte(map_addr);
        end else begin
            map_ack  <= 1'b0;
            map_data <= ~map_data;
        end
        if (cyc_cnt == 40000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic wb_xfer(input logic w, input logic [13:0] idx, input logic [7:0] v);
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {idx, 2'b00};
        sel   <= 4'h1;
        dat_w <= {24'h00_0000, v};
        do @(posedge clk_i); while (ack !== 1'b1);
        d = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Start a pass, optionally poke a sequence byte while busy, then check the stream
    task automatic run_pass(input logic [8:0][7:0] s, input logic slow, input logic poke);
        int          p, k;
        logic [15:0] a, n0;
        slow_mode <= slow;
        n0 = n_wr;
        wb_xfer(1'b1, IDX_CTRL, 8'h01);
        if (poke) wb_xfer(1'b1, IDX_LOOP_ONE_GENERAL_INSTR, 8'h00);
        k = 0;
        do begin
            wb_xfer(1'b0, IDX_STATUS, 8'h00);
            k++;
        end while (d[STAT_DONE_BIT] !== 1'b1 && k < 4000);
        p = 0;
        for (int e = 0; e < 3; e++) begin
            a = {s[3*e+1], s[3*e+2]};
            `CHK(u_eeprom_model.mem[p], s[3*e])
            `CHK(u_eeprom_model.mem[p+1], s[3*e+1])
            `CHK(u_eeprom_model.mem[p+2], s[3*e+2])
            p += 3;
            for (int j = 0; j <= int'(s[3*e]); j++) begin
                `CHK(u_eeprom_model.mem[p], map_byte(a + 16'(j)))
                p++;
            end
        end
        `CHK(n_wr - n0, 16'(p))
        wb_xfer(1'b0, IDX_POINTER, 8'h00);
        `CHK(d[15:0], 16'(p))
        wb_xfer(1'b0, IDX_LOOP_ONE_GENERAL_INSTR, 8'h00);
        `CHK(d, {24'h00_0000, s[6]})
        wb_xfer(1'b1, IDX_STATUS, 8'h02);
        wb_xfer(1'b0, IDX_STATUS, 8'h00);
        `CHK(d[STAT_DONE_BIT], 1'b0)
    endtask

    task automatic wrap_up();
        $display("errors %0d, checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 16'h0000; sel = 4'h0;
        dat_w = 32'h0000_0000; map_ack = 1'b0; map_data = 8'h00; slow_mode = 1'b0;
        err_total = 0; n_tests = 0; cyc_cnt = 0;
        // Element 0 is the lowest sequence index
        dflt = {8'h00, 8'h05, 8'h1e, 8'h40, 8'h04, 8'h33, 8'h30, 8'h04, 8'h0e};
        cust = {8'hff, 8'h00, 8'h02, 8'hfe, 8'hab, 8'h01, 8'h34, 8'h12, 8'h00};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset image of the sequence, upper address byte first
        for (int i = 0; i < 9; i++) begin
            wb_xfer(1'b0, IDX_SEQ_FIRST + 14'(i), 8'h00);
            `CHK(d, {24'h00_0000, dflt[i]})
        end
        // Unmapped place ignores writes and reads zero
        wb_xfer(1'b1, 14'h0e50, 8'h5a);
        wb_xfer(1'b0, 14'h0e50, 8'h00);
        `CHK(d, 32'h0000_0000)
        // Default pass on a stalling memory; write while busy must be dropped
        run_pass(dflt, 1'b1, 1'b1);
        // Shortest move, carry across the low address byte, prompt memory
        for (int i = 0; i < 9; i++) begin
            wb_xfer(1'b1, IDX_SEQ_FIRST + 14'(i), cust[i]);
            wb_xfer(1'b0, IDX_SEQ_FIRST + 14'(i), 8'h00);
            `CHK(d, {24'h00_0000, cust[i]})
        end
        run_pass(cust, 1'b0, 1'b0);
        // Reset while idle after the pass must bring every rewritten sequence byte back to its default
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            wb_xfer(1'b0, IDX_SEQ_FIRST + 14'(i), 8'h00);
            `CHK(d, {24'h00_0000, dflt[i]})
        end
        wrap_up();
    end
endmodule
